// ==== hw/mih_pkg.sv ====
// Constants, types and state layout of the interrupt handler
// How it works
// R1: Fourteen sources, each low or high priority
// R2: Valid event sets pending flag regardless of enable
// R3: Enabled pending flag vectors after current instruction
// R4: Return-from-irq resumes interrupted program flow
// R5: Disabled source keeps flag but is ignored
// R6: Global enable gates every individual enable
// R7: Global clear lags one cycle for next instruction
// R8: Software follows global clear with two-byte opcode
// R9: Hardware clears some flags; software clears rest
// R10: Flag left after return re-enters after one instruction
// R11: Software write of one acts as event
// R12: Ext input edge/level and polarity selectable
// R13: Ext inputs sample selected pins, read only
// R14: Ext pending flags are timer control bits 1,3
// R15: Edge-mode ext flag cleared on vectoring
// R16: Level-mode ext flag follows the input level
// R17: Level source holds until recognised, then releases
// R18: High preempts low; high never preempted
// R19: Same level served in fixed slot order
// R20: Sampled every clock; four-cycle forced call
// R21: Ext pins synchronised, polarity then edge compare
package mih_pkg;
  // *************************************************
  // Slots, masks and vectors
  // *************************************************
  localparam int NSLOT = 15; // Slot 8 is reserved
  localparam logic [14:0] SLOT_USED = 15'h7EFF;
  localparam logic [14:0] HW_CLR_MASK = 15'h000A; // Timer 0/1
  localparam logic [14:0] PERIPH_MASK = 15'h7EFA; // All used slots but ext
  localparam logic [3:0] SLOT_EXT0 = 4'h0;
  localparam logic [3:0] SLOT_EXT1 = 4'h2;
  localparam logic [3:0] SLOT_T0 = 4'h1;
  localparam logic [3:0] SLOT_T1 = 4'h3;
  localparam logic [15:0] VEC_FIRST = 16'h0003;
  localparam int VEC_SHIFT = 3; // Vectors eight bytes apart
  // *************************************************
  // Field positions
  // *************************************************
  localparam int TC_EXT0 = 1;
  localparam int TC_EXT1 = 3;
  localparam int TC_T0 = 5;
  localparam int TC_T1 = 7;
  localparam int CFG_SEL0_LSB = 0;
  localparam int CFG_POL0_BIT = 3;
  localparam int CFG_SEL1_LSB = 4;
  localparam int CFG_POL1_BIT = 7;
  // *************************************************
  // Timing
  // *************************************************
  localparam logic [2:0] CALL_CYCLES = 3'h4; // Forced long call
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  // *************************************************
  // State
  // *************************************************
  typedef enum logic [0:0] {ST_RUN, ST_CALL} mih_state_e;
  typedef struct packed {
    mih_state_e st;
    logic [2:0] cnt;
    logic [14:0] pend;
    logic ea;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] act_prev;
    logic in_low;
    logic in_high;
    logic take;
    logic [15:0] vec_addr;
    logic [3:0] vec_id;
  } mih_state_s;
  // Edge history starts as if both inputs were active: the zero that the
  // synchroniser holds after reset would otherwise look like a fresh edge
  // on an active-low input and set its flag with no pin activity at all
  localparam mih_state_s MIH_RESET = '{st: ST_RUN, act_prev: 2'h3, default: '0};
endpackage

// ==== hw/mih_top.sv ====
// Interrupt handler: pending flags, ext inputs, arbitration, vectoring
module mih_top
  import mih_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Peripheral flag sources, one-cycle pulses
  input wire logic [14:0] SRC_EVENT,
  // Software flag writes, one-cycle pulses
  input wire logic [14:0] SW_SET,
  input wire logic [14:0] SW_CLR,
  // Enables and priorities
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic [14:0] SRC_ENABLE,
  input wire logic [14:0] SRC_PRIORITY,
  // External inputs
  input wire logic [7:0] PORT_PINS,
  input wire logic [7:0] EXT_IRQ_CONFIG,
  input wire logic EXT0_EDGE_SELECT,
  input wire logic EXT1_EDGE_SELECT,
  // Instruction sequencer
  input wire logic INSN_DONE,
  input wire logic RETURN_FROM_IRQ_DONE,
  output logic IRQ_REQUEST,
  output logic VECTOR_TAKE,
  output logic LONG_CALL_ACTIVE,
  output logic [15:0] VECTOR_ADDR,
  output logic [3:0] VECTOR_ID,
  output logic IN_HIGH_ISR,
  // Flag view
  output logic [14:0] PENDING,
  output logic EXT0_PENDING,
  output logic EXT1_PENDING,
  output logic [7:0] TIMER_CONTROL_IRQ
);

  mih_state_s cur_q; // Registered state
  mih_state_s nxt_d; // Next state
  logic ext0_polarity; // One means active high
  logic ext1_polarity;
  logic [2:0] ext0_sel; // Pin choice for ext input 0
  logic [2:0] ext1_sel;
  logic [1:0] act; // Inputs as active-high levels
  logic [1:0] edge_ev; // Active edges seen this cycle
  logic [14:0] events; // Everything that sets a flag, bar level-mode ext inputs
  logic [14:0] hw_clr; // Flags cleared on vectoring
  logic [14:0] clr; // All clears
  logic [14:0] en; // Effective enables
  logic [14:0] elig_hi; // High-level candidates
  logic [14:0] elig_lo; // Low-level candidates
  logic [3:0] sel; // Winning slot
  logic sel_high; // Winner is high level
  logic req; // Some candidate exists
  logic take; // Vector this cycle

  // Lowest-numbered set bit wins
  function automatic logic [3:0] first_one(input logic [14:0] v);
    logic [3:0] r;
    r = '0;
    for (int i = NSLOT - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // *************************************************
  // External input conditioning
  // *************************************************
  assign ext0_polarity = EXT_IRQ_CONFIG[CFG_POL0_BIT];
  assign ext1_polarity = EXT_IRQ_CONFIG[CFG_POL1_BIT];
  assign ext0_sel = EXT_IRQ_CONFIG[CFG_SEL0_LSB +: 3];
  assign ext1_sel = EXT_IRQ_CONFIG[CFG_SEL1_LSB +: 3];

  // Polarity folds first, so edge compare sees active-high
  always_comb
  begin
    act[0] = ext0_polarity ? cur_q.sync2[0] : ~cur_q.sync2[0]; // R12 R21
    act[1] = ext1_polarity ? cur_q.sync2[1] : ~cur_q.sync2[1]; // R12 R21
    edge_ev = act & ~cur_q.act_prev; // R21
  end

  // *************************************************
  // Arbitration
  // *************************************************
  // Enables lag global enable one cycle, as the core does
  assign en = SRC_ENABLE & {NSLOT{cur_q.ea}} & SLOT_USED; // R6 R5

  always_comb
  begin
    // High level only blocked by a running high routine
    elig_hi = cur_q.in_high ? '0 : (cur_q.pend & en & SRC_PRIORITY); // R18
    // Low level waits for any running routine
    elig_lo = (cur_q.in_high || cur_q.in_low) ? '0 : (cur_q.pend & en & ~SRC_PRIORITY); // R18
    sel_high = |elig_hi; // R19
    sel = sel_high ? first_one(elig_hi) : first_one(elig_lo); // R19 R1
    req = sel_high || (|elig_lo); // R3
    // The done of a return never vectors: one more insn runs
    take = INSN_DONE && !RETURN_FROM_IRQ_DONE && req && (cur_q.st == ST_RUN); // R3 R10 R20
  end

  // *************************************************
  // Next state
  // *************************************************
  always_comb
  begin
    nxt_d = cur_q;
    nxt_d.take = take;
    nxt_d.ea = GLOBAL_IRQ_ENABLE; // R7
    // Pin sampling only reads the pad; no drive back
    nxt_d.sync1 = {PORT_PINS[ext1_sel], PORT_PINS[ext0_sel]}; // R13 R21
    nxt_d.sync2 = cur_q.sync1; // R21
    nxt_d.act_prev = act; // R21
    // Events, software sets included, beat every clear
    events = SRC_EVENT | SW_SET; // R2 R11
    events[SLOT_EXT0] = SRC_EVENT[SLOT_EXT0] | SW_SET[SLOT_EXT0]
      | (EXT0_EDGE_SELECT & edge_ev[0]); // R12
    events[SLOT_EXT1] = SRC_EVENT[SLOT_EXT1] | SW_SET[SLOT_EXT1]
      | (EXT1_EDGE_SELECT & edge_ev[1]); // R12
    // Only timers and edge-mode ext flags self-clear
    hw_clr = HW_CLR_MASK; // R9
    hw_clr[SLOT_EXT0] = EXT0_EDGE_SELECT; // R15
    hw_clr[SLOT_EXT1] = EXT1_EDGE_SELECT; // R15
    hw_clr = take ? (hw_clr & (15'h0001 << sel)) : '0; // R9
    clr = SW_CLR | hw_clr;
    nxt_d.pend = ((cur_q.pend & ~clr) | events) & SLOT_USED; // R2
    // Level mode: flag mirrors the input, nothing latches
    if (!EXT0_EDGE_SELECT)
    begin
      nxt_d.pend[SLOT_EXT0] = act[0]; // R16
    end
    if (!EXT1_EDGE_SELECT)
    begin
      nxt_d.pend[SLOT_EXT1] = act[1]; // R16
    end
    // Return pops the innermost level
    if (RETURN_FROM_IRQ_DONE)
    begin
      if (cur_q.in_high)
      begin
        nxt_d.in_high = 1'b0; // R4
      end
      else
      begin
        nxt_d.in_low = 1'b0; // R4
      end
    end
    case (cur_q.st)
      ST_RUN:
      begin
        // Start the forced call and mark the level busy
        if (take)
        begin
          nxt_d.st = ST_CALL; // R20
          nxt_d.cnt = CALL_CYCLES - CNT_ONE;
          nxt_d.vec_id = sel;
          nxt_d.vec_addr = VEC_FIRST + (16'(sel) << VEC_SHIFT); // R3
          if (sel_high)
          begin
            nxt_d.in_high = 1'b1; // R18
          end
          else
          begin
            nxt_d.in_low = 1'b1; // R18
          end
        end
      end
      ST_CALL:
      begin
        // Count down the call cycles
        if (cur_q.cnt == CNT_ZERO)
        begin
          nxt_d.st = ST_RUN;
        end
        else
        begin
          nxt_d.cnt = cur_q.cnt - CNT_ONE; // R20
        end
      end
      default:
      begin
        nxt_d.st = ST_RUN;
      end
    endcase
  end

  // Single register for all state
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      cur_q <= MIH_RESET;
    end
    else
    begin
      cur_q <= nxt_d;
    end
  end

  // *************************************************
  // Outputs
  // *************************************************
  assign IRQ_REQUEST = req;
  assign VECTOR_TAKE = cur_q.take;
  assign LONG_CALL_ACTIVE = (cur_q.st == ST_CALL);
  assign VECTOR_ADDR = cur_q.vec_addr;
  assign VECTOR_ID = cur_q.vec_id;
  assign IN_HIGH_ISR = cur_q.in_high;
  assign PENDING = cur_q.pend;
  assign EXT0_PENDING = cur_q.pend[SLOT_EXT0];
  assign EXT1_PENDING = cur_q.pend[SLOT_EXT1];

  // Timer control view: ext flags at bits 1 and 3
  always_comb
  begin
    TIMER_CONTROL_IRQ = '0;
    TIMER_CONTROL_IRQ[TC_EXT0] = cur_q.pend[SLOT_EXT0]; // R14
    TIMER_CONTROL_IRQ[TC_EXT1] = cur_q.pend[SLOT_EXT1]; // R14
    TIMER_CONTROL_IRQ[TC_T0] = cur_q.pend[SLOT_T0];
    TIMER_CONTROL_IRQ[TC_T1] = cur_q.pend[SLOT_T1];
  end

  // *************************************************
  // Assertions
  // *************************************************
  sequence s_call;
    LONG_CALL_ACTIVE [*4];
  endsequence

  property p_call_len;
    @(posedge CLK_SYS) disable iff (!RSTN)
      take |=> s_call ##1 !LONG_CALL_ACTIVE;
  endproperty
  a_call_len: assert property (p_call_len) // R20
    else $error("forced call not four cycles");

  property p_global_gate;
    @(posedge CLK_SYS) disable iff (!RSTN)
      !$past(GLOBAL_IRQ_ENABLE) |-> !take;
  endproperty
  a_global_gate: assert property (p_global_gate) // R6
    else $error("vectored with global enable off");

  property p_enabled_only;
    @(posedge CLK_SYS) disable iff (!RSTN)
      take |-> (cur_q.pend[sel] && SRC_ENABLE[sel]);
  endproperty
  a_enabled_only: assert property (p_enabled_only) // R5
    else $error("vectored to disabled or idle slot");

  property p_vec_addr;
    @(posedge CLK_SYS) disable iff (!RSTN)
      take |=> VECTOR_TAKE && VECTOR_ADDR == VEC_FIRST + (16'($past(sel)) << VEC_SHIFT);
  endproperty
  a_vec_addr: assert property (p_vec_addr) // R3
    else $error("wrong vector address");

  property p_edge_clear;
    @(posedge CLK_SYS) disable iff (!RSTN)
      take && sel == SLOT_EXT0 && EXT0_EDGE_SELECT && !events[SLOT_EXT0]
        |=> !EXT0_PENDING;
  endproperty
  a_edge_clear: assert property (p_edge_clear) // R15
    else $error("edge flag not cleared on vectoring");

  property p_level_follow;
    @(posedge CLK_SYS) disable iff (!RSTN)
      !EXT1_EDGE_SELECT |=> EXT1_PENDING == $past(act[1]);
  endproperty
  a_level_follow: assert property (p_level_follow) // R16
    else $error("level flag does not follow input");

  property p_high_hold;
    @(posedge CLK_SYS) disable iff (!RSTN)
      IN_HIGH_ISR |-> !take;
  endproperty
  a_high_hold: assert property (p_high_hold) // R18
    else $error("high routine preempted");

  property p_return_from_irq_gap;
    @(posedge CLK_SYS) disable iff (!RSTN)
      RETURN_FROM_IRQ_DONE |-> !take;
  endproperty
  a_return_from_irq_gap: assert property (p_return_from_irq_gap) // R10
    else $error("vectored on return instruction");

  property p_high_first;
    @(posedge CLK_SYS) disable iff (!RSTN)
      take && |(cur_q.pend & en & SRC_PRIORITY) && !IN_HIGH_ISR
        |-> SRC_PRIORITY[sel];
  endproperty
  a_high_first: assert property (p_high_first) // R19
    else $error("low level served before high");

  property p_set_wins;
    @(posedge CLK_SYS) disable iff (!RSTN)
      |(SW_SET & PERIPH_MASK) |=> (PENDING & $past(SW_SET & PERIPH_MASK))
        == $past(SW_SET & PERIPH_MASK);
  endproperty
  a_set_wins: assert property (p_set_wins) // R11
    else $error("software set lost");

endmodule

// ==== bench/mih_cpu_model.sv ====
// Partner model: instruction sequencer issuing completion strobes
module mih_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Return request from the bench
  input wire logic return_from_irq_req,
  // Completion strobes
  output logic insn_done,
  output logic return_from_irq_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req_q = 1'b0; // Request seen at the clock edge
  logic pend = 1'b0; // Return waiting for a completion
  int gap = 0; // Cycles left in this instruction
  int len = 1; // Lengths cycle 1..3, so slow and fast both occur
  // *********
  // Strobes
  // *********
  always @(posedge clk)
    req_q <= return_from_irq_req;
  // Change on the falling edge, stable at the sampling edge
  always @(negedge clk)
  begin
    if (req_q)
      pend = 1'b1;
    insn_done = 1'b0;
    return_from_irq_done = 1'b0;
    if (!rstn)
      gap = 0;
    else if (gap == 0)
    begin
      insn_done = 1'b1;
      return_from_irq_done = pend;
      pend = 1'b0;
      gap = len;
      len = len % 3 + 1;
    end
    else
      gap--;
  end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench of the interrupt handler
module testbench;
  import mih_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  logic [14:0] SRC_EVENT = '0;
  logic [14:0] SW_SET = '0;
  logic [14:0] SW_CLR = '0;
  logic GLOBAL_IRQ_ENABLE = 1'b0;
  logic [14:0] SRC_ENABLE = '0;
  logic [14:0] SRC_PRIORITY = '0;
  // Ext0 on pin 2 active high, ext1 on pin 5 active low
  logic [7:0] PORT_PINS = 8'h20;
  logic [7:0] EXT_IRQ_CONFIG = 8'h5A;
  logic EXT0_EDGE_SELECT = 1'b0;
  logic EXT1_EDGE_SELECT = 1'b1;
  logic INSN_DONE, RETURN_FROM_IRQ_DONE, return_from_irq_req = 1'b0;
  logic IRQ_REQUEST, VECTOR_TAKE, LONG_CALL_ACTIVE, IN_HIGH_ISR;
  logic [15:0] VECTOR_ADDR;
  logic [3:0] VECTOR_ID;
  logic [14:0] PENDING, m, p;
  logic EXT0_PENDING, EXT1_PENDING;
  logic [7:0] TIMER_CONTROL_IRQ;
  logic [3:0] id;
  logic [31:0] rs = 32'd49161; // Xorshift state
  int n_errors = 0;
  int n_compared = 0;
  initial
    forever #20 CLK_SYS = ~CLK_SYS;
  mih_top mih_top_inst (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .SRC_EVENT(SRC_EVENT),
    .SW_SET(SW_SET), .SW_CLR(SW_CLR), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .SRC_ENABLE(SRC_ENABLE), .SRC_PRIORITY(SRC_PRIORITY), .PORT_PINS(PORT_PINS),
    .EXT_IRQ_CONFIG(EXT_IRQ_CONFIG), .EXT0_EDGE_SELECT(EXT0_EDGE_SELECT),
    .EXT1_EDGE_SELECT(EXT1_EDGE_SELECT), .INSN_DONE(INSN_DONE),
    .RETURN_FROM_IRQ_DONE(RETURN_FROM_IRQ_DONE), .IRQ_REQUEST(IRQ_REQUEST), .VECTOR_TAKE(VECTOR_TAKE),
    .LONG_CALL_ACTIVE(LONG_CALL_ACTIVE), .VECTOR_ADDR(VECTOR_ADDR), .VECTOR_ID(VECTOR_ID),
    .IN_HIGH_ISR(IN_HIGH_ISR), .PENDING(PENDING), .EXT0_PENDING(EXT0_PENDING),
    .EXT1_PENDING(EXT1_PENDING), .TIMER_CONTROL_IRQ(TIMER_CONTROL_IRQ));
  mih_cpu_model mih_cpu_model_inst (.clk(CLK_SYS), .rstn(RSTN),
    .return_from_irq_req(return_from_irq_req), .insn_done(INSN_DONE), .return_from_irq_done(RETURN_FROM_IRQ_DONE));
  // *********
  // Helpers
  // *********
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Expected winner: high level first, then lowest slot
  function automatic logic [3:0] pick(logic [14:0] f, logic [14:0] pr);
    for (int l = 1; l >= 0; l--)
      for (int i = 0; i < 15; i++)
        if (f[i] && pr[i] == l)
          return 4'(i);
    return 4'h0;
  endfunction
  task step(int n);
    repeat (n) @(negedge CLK_SYS);
  endtask
  task chk(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task end_sim;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Wait for a vector, then count the forced call length
  task tk;
    int i, c;
    i = 0;
    c = 0;
    while (VECTOR_TAKE !== 1'b1 && i < 40)
    begin
      step(1);
      i++;
    end
    if (i >= 40)
    begin
      $display("[ERR] %0t got %h exp %h", $time, VECTOR_TAKE, 1'b1);
      n_errors++;
      end_sim;
    end
    repeat (6)
    begin
      if (LONG_CALL_ACTIVE === 1'b1)
        c++;
      step(1);
    end
    chk(16'(c), 16'h0004);
  endtask
  // Software clears every flag, then returns
  task isr_end;
    SW_CLR = '1;
    step(1);
    SW_CLR = '0;
    return_from_irq_req = 1'b1;
    step(1);
    return_from_irq_req = 1'b0;
    step(8);
  endtask
  // *********
  // Sequence
  // *********
  initial
  begin
    step(5);
    RSTN = 1'b1;
    step(1);
    chk({PENDING, IRQ_REQUEST}, 16'h0000);
    chk({VECTOR_TAKE, LONG_CALL_ACTIVE, IN_HIGH_ISR, TIMER_CONTROL_IRQ}, 16'h0000);
    // Disabled event still flags, no request
    SRC_EVENT[5] = 1'b1;
    step(1);
    SRC_EVENT = '0;
    step(2);
    chk(PENDING, 16'h0020);
    chk(IRQ_REQUEST, 16'h0000);
    SRC_ENABLE[5] = 1'b1;
    step(2);
    chk(IRQ_REQUEST, 16'h0000);
    GLOBAL_IRQ_ENABLE = 1'b1;
    tk;
    chk({VECTOR_ID, VECTOR_ADDR[11:0]}, 16'h502B);
    // High request preempts the low routine
    SRC_ENABLE[9] = 1'b1;
    SRC_PRIORITY[9] = 1'b1;
    SW_SET[9] = 1'b1;
    step(1);
    SW_SET = '0;
    tk;
    chk({VECTOR_ID, 3'h0, IN_HIGH_ISR}, 16'h0091);
    isr_end;
    chk(IN_HIGH_ISR, 16'h0000);
    isr_end;
    // Ext inputs, global enable off; nothing pending as it drops
    GLOBAL_IRQ_ENABLE = 1'b0;
    PORT_PINS = 8'h24;
    step(4);
    chk({EXT0_PENDING, TIMER_CONTROL_IRQ}, 16'h0102);
    PORT_PINS = 8'h04;
    step(4);
    chk(TIMER_CONTROL_IRQ, 16'h000A);
    PORT_PINS = 8'h20;
    step(4);
    chk({EXT1_PENDING, TIMER_CONTROL_IRQ}, 16'h0108);
    SRC_ENABLE = 15'h0004;
    GLOBAL_IRQ_ENABLE = 1'b1;
    tk;
    chk({VECTOR_ID, 3'h0, EXT1_PENDING}, 16'h0020);
    isr_end;
    // Random flag sets and priorities
    SRC_ENABLE = '1;
    repeat (20)
    begin
      rs = xs(rs);
      m = (rs[14:0] & PERIPH_MASK) | 15'h0040;
      p = rs[30:16];
      id = pick(m, p);
      SRC_PRIORITY = p;
      SW_SET = m;
      step(1);
      SW_SET = '0;
      tk;
      chk(VECTOR_ID, 16'(id));
      chk(VECTOR_ADDR, 16'h0003 + 16'(id) * 16'h0008);
      chk(IN_HIGH_ISR, 16'(p[id]));
      chk(PENDING, m & ~(HW_CLR_MASK & (15'h0001 << id)));
      isr_end;
    end
    // Swap modes: ext0 edge, ext1 level, both raised together
    SRC_PRIORITY = '0;
    EXT0_EDGE_SELECT = 1'b1;
    EXT1_EDGE_SELECT = 1'b0;
    PORT_PINS = 8'h04;
    tk;
    chk({VECTOR_ID, 2'h0, EXT0_PENDING, EXT1_PENDING}, 16'h0001);
    // Level source still held at return: one more insn, then back in
    SW_CLR = '1;
    step(1);
    SW_CLR = '0;
    return_from_irq_req = 1'b1;
    step(1);
    return_from_irq_req = 1'b0;
    tk;
    chk(VECTOR_ID, 16'h0002);
    // Source lets go before its routine ends: no further request
    PORT_PINS = 8'h24;
    step(4);
    chk(EXT1_PENDING, 16'h0000);
    isr_end;
    chk(IRQ_REQUEST, 16'h0000);
    end_sim;
  end
endmodule
